// [soft_strap_default_loader_tb_top.sv]
// self-checking bench for the soft strap default loader
`timescale 1ns/1ps
module soft_strap_default_loader_tb_top;
    import ssd_pkg::*;
    logic aclk = 0, aresetn = 0, prst_n = 1, pin = 1, eel = 0, eep = 0;
    logic [3:0] ws = 4'hF;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic awr, wr_r, bv, arr, rv, xen, xcr, an, hb;
    logic [2:0] mode = 3'h7;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [DATA_W-1:0] wd = '0, rdt, d;
    logic [1:0] bresp, rresp, rs;
    logic [5:0] ien;
    logic [1:0] ifn;
    ssd_straps_t eed = STRAPS_RST;
    int bad_count = 0, checked = 0, cyc = 0;
    ssd_loader dut (.aclk(aclk), .aresetn(aresetn), .pin_reset_n(prst_n),
        .indicator0_shared_pin(pin), .p1_mode(mode), .eeprom_present(eep),
        .ee_load(eel), .ee_data(eed), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdt),
        .s_axi_rresp(rresp), .indicator_enable_field(ien),
        .indicator_function_field(ifn), .p1_auto_crossover_en(xen),
        .p1_crossed_wiring(xcr), .negotiation_enable_bit(an),
        .heartbeat_test_off_bit(hb));
    always #12.5 aclk = ~aclk;
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            test_done;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e)
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        if (g !== e)
            bad_count++;
    endtask
    // each channel is released at the edge that takes it
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        awa <= a;
        wd <= v;
        awv <= 1;
        wv <= 1;
        br <= 1;
        do
        begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 0;
            if (wr_r === 1'b1) wv <= 0;
        end while (bv !== 1'b1);
        br <= 0;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] m, e,
                      input string nm);
        ara <= a;
        arv <= 1;
        rr <= 1;
        do
        begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 0;
        end while (rv !== 1'b1);
        d = rdt;
        rs = rresp;
        rr <= 0;
        @(posedge aclk);
        chk(nm, e, d & m);
    endtask
    task automatic ee(input ssd_straps_t s);
        eed <= s;
        eel <= 1;
        @(posedge aclk);
        eel <= 0;
        repeat (4) @(posedge aclk);
    endtask
    task automatic t_dflt;
        rc(IND_CFG_OFS, 32'h0000_033F, 32'h0000_003F, "ind");
        chk("ind_out", 32'h0000_00FC, {24'h0, ien, ifn});
        rc(HARDWARE_CONFIG_REG_OFS, 32'h0000_0001, 32'h0000_0001, "hw");
        chk("xover", 32'h0000_0002, {30'h0, xen, xcr});
        rc(PHY_CTRL_OFS, 32'h0000_3100, 32'h0000_3100, "ctl");
        rc(ADVERT_OFS, 32'h0000_0060, 32'h0000_0060, "adv");
        rc(SPMODE_OFS, 32'h0000_00E0, 32'h0000_00E0, "mode");
        $display("defaults done");
    endtask
    task automatic t_restore;
        ee('{6'h15, 2'h2, 1'b0, 1'b1, 1'b1, 1'b0});
        rc(IND_CFG_OFS, 32'h0000_033F, 32'h0000_0215, "ee");
        chk("man_x", 32'h0000_0001, {30'h0, xen, xcr});
        rc(STATUS_OFS, 32'h0000_0003, 32'h0000_0003, "ovr");
        pin <= 0;
        wr(RST_CTRL_OFS, 32'h0000_0001);
        repeat (4) @(posedge aclk);
        rc(IND_CFG_OFS, 32'h0000_033F, 32'h0000_003F, "rst");
        rc(HARDWARE_CONFIG_REG_OFS, 32'h0000_0001, 32'h0000_0001, "nosmp");
        rc(STATUS_OFS, 32'h0000_0003, 32'h0000_0001, "unovr");
        ee('{6'h15, 2'h2, 1'b0, 1'b1, 1'b1, 1'b0});
        eep <= 1;
        wr(RST_CTRL_OFS, 32'h0000_0002);
        rc(IND_CFG_OFS, 32'h0000_033F, 32'h0000_0215, "keep");
        eep <= 0;
        wr(RST_CTRL_OFS, 32'h0000_0002);
        rc(IND_CFG_OFS, 32'h0000_033F, 32'h0000_003F, "reload");
        $display("restore done");
    endtask
    task automatic t_sw;
        wr(IND_CFG_OFS, 32'h0000_0105);
        repeat (6) @(posedge aclk);
        rc(IND_CFG_OFS, 32'h0000_033F, 32'h0000_0105, "sw");
        chk("sw_out", 32'h0000_0015, {24'h0, ien, ifn});
        rc(6'h3C, 32'h0000_0000, 32'h0000_0000, "unmap");
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        ws <= 4'h2;
        wr(IND_CFG_OFS, 32'h0000_0300);
        ws <= 4'hF;
        rc(IND_CFG_OFS, 32'h0000_033F, 32'h0000_0305, "strb");
        wr(SPCTRL_OFS, 32'h0000_6000);
        chk("man_ctl", 32'h0000_0001, {30'h0, xen, xcr});
        $display("software hold done");
    endtask
    task automatic t_pin_mode;
        prst_n <= 0;
        repeat (4) @(posedge aclk);
        prst_n <= 1;
        repeat (8) @(posedge aclk);
        rc(HARDWARE_CONFIG_REG_OFS, 32'h0000_0001, 32'h0000_0000, "pin");
        mode <= MODE_MII_PHY;
        ee('{6'h3F, 2'h0, 1'b1, 1'b1, 1'b0, 1'b1});
        chk("ign_x", 32'h0000_0000, {30'h0, xen, xcr});
        chk("hb", 32'h0000_0001, {31'h0, hb});
        mode <= MODE_MII_MAC;
        ee('{6'h3F, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1});
        chk("hb_ign", 32'h0000_0000, {31'h0, hb});
        $display("pin and mode done");
    endtask
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        t_dflt;
        t_restore;
        t_sw;
        t_pin_mode;
        test_done;
    end
endmodule

// [ssd_loader.sv]
// soft strap default loader with axi4-lite register access
`timescale 1ns/1ps
// What this block does
// R1: indicator enable field loads from six straps, each tied to one.
// R2: indicator function field loads from two straps tied to zero.
// R3: sampled shared-pin crossover strap shows in hardware config state bit.
// R4: auto and manual crossover straps steer port 1 in strap mode.
// R5: manual strap, default zero, picks straight or crossed when auto low.
// R6: crossover straps ignored unless port 1 uses the internal phy.
// R7: negotiation enable loads from strap; strap is one only in internal mode.
// R8: negotiation strap shapes speed, duplex, advert bits and mode field.
// R9: heartbeat-off bit loads from strap only in mii phy mode.
// R10: straps latch at power-on or pin reset release; loader overrides.
// R11: digital reset or failed reload restores latched values, no resample.
// R12: defaults hold until software writes, a reset or the loader reloads them.
module ssd_loader
    import ssd_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 pin_reset_n,
    input  wire logic                 indicator0_shared_pin,
    input  wire logic [2:0]           p1_mode,
    input  wire logic                 eeprom_present,
    input  wire logic                 ee_load,
    input  wire ssd_straps_t          ee_data,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [DATA_W-1:0]    s_axi_wdata,
    input  wire logic [STRB_W-1:0]    s_axi_wstrb,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic [IND_EN_W-1:0]       indicator_enable_field,
    output logic [IND_FUN_W-1:0]      indicator_function_field,
    output logic                      p1_auto_crossover_en,
    output logic                      p1_crossed_wiring,
    output logic                      negotiation_enable_bit,
    output logic                      heartbeat_test_off_bit
);
    ssd_strap_if sif ();

    ssd_strap_latch u_latch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sif     (sif)
    );

    // pins cross two flops; edge detect looks only at stage two and three
    logic pr_s1_q, pr_s2_q, pr_s3_q, px_s1_q, px_s2_q, por_q;

    // strap pin sync runs through reset so the power-on sample sees the pin
    always_ff @(posedge aclk)
    begin
        px_s1_q <= indicator0_shared_pin;
        px_s2_q <= px_s1_q;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pr_s1_q <= 1'b1;
            pr_s2_q <= 1'b1;
            pr_s3_q <= 1'b1;
            por_q   <= 1'b1;
        end
        else
        begin
            pr_s1_q <= pin_reset_n;
            pr_s2_q <= pr_s1_q;
            pr_s3_q <= pr_s2_q;
            por_q   <= 1'b0;
        end
    end

    // ---------------- axi4-lite slave ----------------
    logic              awready_q, awready_d, wready_q, wready_d;
    logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic              bvalid_q, bvalid_d, arready_q, arready_d;
    logic              rvalid_q, rvalid_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [STRB_W-1:0] wstrb_q, wstrb_d;
    logic              do_write;

    // register state
    logic [IND_EN_W-1:0]  ind_en_q, ind_en_d;
    logic [IND_FUN_W-1:0] ind_fun_q, ind_fun_d;
    logic                 autox_st_q, autox_st_d, an_q, an_d;
    logic                 speed_q, speed_d, duplex_q, duplex_d;
    logic [1:0]           adv_q, adv_d;
    logic [2:0]           mode_q, mode_d, xctl_q, xctl_d;
    logic                 hb_off_q, hb_off_d, x_auto_q, x_auto_d;
    logic                 x_cross_q, x_cross_d, restore_q, restore_d;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == IND_CFG_OFS || a == HARDWARE_CONFIG_REG_OFS || a == PHY_CTRL_OFS
            || a == ADVERT_OFS || a == SPMODE_OFS || a == SPCTRL_OFS
            || a == MIF_CTRL_OFS || a == RST_CTRL_OFS || a == STATUS_OFS;
    endfunction

    function automatic logic [DATA_W-1:0] rd_val(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        case (a)
            IND_CFG_OFS:
            begin
                v[IND_EN_LSB +: IND_EN_W]   = ind_en_q;
                v[IND_FUN_LSB +: IND_FUN_W] = ind_fun_q;
            end
            HARDWARE_CONFIG_REG_OFS:   v[HW_AUTOX_BIT] = autox_st_q;
            PHY_CTRL_OFS:
            begin
                v[AN_BIT]     = an_q;
                v[SPEED_BIT]  = speed_q;
                v[DUPLEX_BIT] = duplex_q;
            end
            ADVERT_OFS:   v[ADV_LSB +: 2]  = adv_q;
            SPMODE_OFS:   v[MODE_LSB +: 3] = mode_q;
            SPCTRL_OFS:   v[XCTL_LSB +: 3] = xctl_q;
            MIF_CTRL_OFS: v[HB_OFF_BIT]    = hb_off_q;
            STATUS_OFS:
            begin
                v[ST_LATCH_BIT] = sif.is_latched;
                v[ST_OVR_BIT]   = sif.override;
            end
            default:      v = '0;
        endcase
        return v;
    endfunction

    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

    always_comb
    begin
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_hold_d = 1'b1;
            waddr_d   = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (do_write)
        begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = is_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rdata_d  = rd_val(s_axi_araddr);
            rresp_d  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d  = !w_hold_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
        end
        else
        begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // ---------------- strap defaults and register writes ----------------
    logic [DATA_W-1:0] bmask, wv;

    always_comb
    begin
        for (int i = 0; i < STRB_W; i++)
            bmask[i*8 +: 8] = {8{wstrb_q[i]}};
        // kept in a process so register changes re-run the merge
        wv = (rd_val(waddr_q) & ~bmask) | (wdata_q & bmask);
    end

    assign sif.sample  = por_q || (pr_s2_q && !pr_s3_q);
    assign sif.restore = restore_q;
    assign sif.ee_load = ee_load;
    assign sif.ee_data = ee_data;
    assign sif.pin_x   = px_s2_q;
    assign sif.p1_mode = p1_mode;

    always_comb
    begin
        ind_en_d   = ind_en_q;
        ind_fun_d  = ind_fun_q;
        autox_st_d = autox_st_q;
        an_d       = an_q;
        speed_d    = speed_q;
        duplex_d   = duplex_q;
        adv_d      = adv_q;
        mode_d     = mode_q;
        xctl_d     = xctl_q;
        hb_off_d   = hb_off_q;
        restore_d  = 1'b0;
        // R12: software writes take over the defaults
        if (do_write)
        begin
            case (waddr_q)
                IND_CFG_OFS:
                begin
                    ind_en_d  = wv[IND_EN_LSB +: IND_EN_W];
                    ind_fun_d = wv[IND_FUN_LSB +: IND_FUN_W];
                end
                PHY_CTRL_OFS:
                begin
                    an_d     = wv[AN_BIT];
                    speed_d  = wv[SPEED_BIT];
                    duplex_d = wv[DUPLEX_BIT];
                end
                ADVERT_OFS:   adv_d    = wv[ADV_LSB +: 2];
                SPMODE_OFS:   mode_d   = wv[MODE_LSB +: 3];
                SPCTRL_OFS:   xctl_d   = wv[XCTL_LSB +: 3];
                MIF_CTRL_OFS: hb_off_d = wv[HB_OFF_BIT];
                // R11: reload without a valid eeprom falls back to straps
                RST_CTRL_OFS: restore_d = wv[DIG_RST_BIT]
                                       || (wv[RELOAD_BIT] && !eeprom_present);
                default:      restore_d = 1'b0;
            endcase
        end
        // a reload of defaults wins over a write in the same cycle
        if (sif.load_dflt)
        begin
            // R1: enable field from straps
            ind_en_d   = sif.eff.ind_en;
            // R2: function field from straps
            ind_fun_d  = sif.eff.ind_fun;
            // R3: crossover strap state bit
            autox_st_d = sif.eff.auto_x;
            // R7: negotiation enable default
            an_d       = sif.eff.an;
            // R8: negotiation strap shapes neighbours
            speed_d    = sif.eff.an || SPEED_TIE;
            duplex_d   = sif.eff.an || DUPLEX_TIE;
            adv_d      = {sif.eff.an || DUPLEX_TIE, 1'b1};
            mode_d     = sif.eff.an ? MODE_INT_PHY
                                    : {1'b0, SPEED_TIE, DUPLEX_TIE};
            // R9: heartbeat strap only in mii phy mode
            hb_off_d   = (p1_mode == MODE_MII_PHY) && sif.eff.hb_off;
        end
        x_auto_d  = 1'b0;
        x_cross_d = 1'b0;
        // R6: straps count only with the internal phy
        if (p1_mode == MODE_INT_PHY)
        begin
            // R4: strap mode combines both straps
            if (xctl_q[XCTL_SEL])
            begin
                x_auto_d  = autox_st_q;
                // R5: manual strap when auto strap low
                x_cross_d = !autox_st_q && sif.eff.manual_x;
            end
            else
            begin
                x_auto_d  = !xctl_q[XCTL_MAN_EN];
                x_cross_d = xctl_q[XCTL_MAN_EN] && xctl_q[XCTL_MAN_VAL];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ind_en_q   <= IND_EN_TIE;
            ind_fun_q  <= IND_FUN_TIE;
            autox_st_q <= 1'b0;
            an_q       <= 1'b0;
            speed_q    <= SPEED_TIE;
            duplex_q   <= DUPLEX_TIE;
            adv_q      <= '0;
            mode_q     <= '0;
            xctl_q     <= XCTL_RST;
            hb_off_q   <= HB_OFF_TIE;
            x_auto_q   <= 1'b0;
            x_cross_q  <= 1'b0;
            restore_q  <= 1'b0;
        end
        else
        begin
            ind_en_q   <= ind_en_d;
            ind_fun_q  <= ind_fun_d;
            autox_st_q <= autox_st_d;
            an_q       <= an_d;
            speed_q    <= speed_d;
            duplex_q   <= duplex_d;
            adv_q      <= adv_d;
            mode_q     <= mode_d;
            xctl_q     <= xctl_d;
            hb_off_q   <= hb_off_d;
            x_auto_q   <= x_auto_d;
            x_cross_q  <= x_cross_d;
            restore_q  <= restore_d;
        end
    end

    assign s_axi_awready            = awready_q;
    assign s_axi_wready             = wready_q;
    assign s_axi_bvalid             = bvalid_q;
    assign s_axi_bresp              = bresp_q;
    assign s_axi_arready            = arready_q;
    assign s_axi_rvalid             = rvalid_q;
    assign s_axi_rdata              = rdata_q;
    assign s_axi_rresp              = rresp_q;
    assign indicator_enable_field   = ind_en_q;
    assign indicator_function_field = ind_fun_q;
    assign p1_auto_crossover_en     = x_auto_q;
    assign p1_crossed_wiring        = x_cross_q;
    assign negotiation_enable_bit   = an_q;
    assign heartbeat_test_off_bit   = hb_off_q;

    // ---------------- checks ----------------
    sequence seq_strap_sample;
        sif.sample && !ee_load;
    endsequence

    sequence seq_defaults_ready;
        ##1 sif.load_dflt ##1 1'b1;
    endsequence

    AST_IND_EN_TIE: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        seq_strap_sample ##0 seq_defaults_ready |-> ind_en_q == IND_EN_TIE)
        else $error("indicator enable not loaded from straps");
    AST_IND_FUN_TIE: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        seq_strap_sample |-> ##2 ind_fun_q == IND_FUN_TIE)
        else $error("indicator function not loaded from straps");
    AST_HW_STATE: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        seq_strap_sample |-> ##2 autox_st_q == $past(px_s2_q, 2))
        else $error("crossover strap state not copied");
    AST_STRAP_XOVER: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        p1_mode == MODE_INT_PHY && xctl_q[XCTL_SEL] && autox_st_q
        |=> x_auto_q && !x_cross_q)
        else $error("auto crossover strap not applied");
    AST_MANUAL_XOVER: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        p1_mode == MODE_INT_PHY && xctl_q[XCTL_SEL] && !autox_st_q
        |=> !x_auto_q && x_cross_q == $past(sif.eff.manual_x))
        else $error("manual crossover strap not applied");
    AST_XOVER_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        p1_mode != MODE_INT_PHY |=> !x_auto_q && !x_cross_q)
        else $error("crossover straps used outside internal phy mode");
    AST_AN_DEFAULT: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        seq_strap_sample ##1 (!ee_load && !do_write)
        |=> an_q == ($past(p1_mode, 2) == MODE_INT_PHY))
        else $error("negotiation default wrong for port mode");
    AST_AN_SHAPES: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        sif.load_dflt && sif.eff.an |=> speed_q && duplex_q
        && adv_q == 2'h3 && mode_q == MODE_INT_PHY)
        else $error("negotiation strap did not shape neighbours");
    AST_HB_OFF_MODE: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        sif.load_dflt && p1_mode != MODE_MII_PHY |=> !hb_off_q)
        else $error("heartbeat strap used outside mii phy mode");
    AST_HOLD_DEFAULTS: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        !sif.load_dflt && !(do_write && waddr_q == IND_CFG_OFS)
        |=> $stable(ind_en_q) && $stable(ind_fun_q))
        else $error("indicator defaults changed without cause");
endmodule

// [ssd_pkg.sv]
// constants, register map and types for the soft strap default loader
package ssd_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] IND_CFG_OFS  = 6'h00;
    localparam logic [ADDR_W-1:0] HARDWARE_CONFIG_REG_OFS   = 6'h04;
    localparam logic [ADDR_W-1:0] PHY_CTRL_OFS = 6'h08;
    localparam logic [ADDR_W-1:0] ADVERT_OFS   = 6'h0C;
    localparam logic [ADDR_W-1:0] SPMODE_OFS   = 6'h10;
    localparam logic [ADDR_W-1:0] SPCTRL_OFS   = 6'h14;
    localparam logic [ADDR_W-1:0] MIF_CTRL_OFS = 6'h18;
    localparam logic [ADDR_W-1:0] RST_CTRL_OFS = 6'h1C;
    localparam logic [ADDR_W-1:0] STATUS_OFS   = 6'h20;

    // field positions
    localparam int IND_EN_LSB   = 0;
    localparam int IND_EN_W     = 6;
    localparam int IND_FUN_LSB  = 8;
    localparam int IND_FUN_W    = 2;
    localparam int HW_AUTOX_BIT = 0;
    localparam int AN_BIT       = 12;
    localparam int SPEED_BIT    = 13;
    localparam int DUPLEX_BIT   = 8;
    localparam int ADV_LSB      = 5;
    localparam int MODE_LSB     = 5;
    localparam int XCTL_LSB     = 13;
    localparam int XCTL_SEL     = 2;
    localparam int XCTL_MAN_EN  = 1;
    localparam int XCTL_MAN_VAL = 0;
    localparam int HB_OFF_BIT   = 11;
    localparam int DIG_RST_BIT  = 0;
    localparam int RELOAD_BIT   = 1;
    localparam int ST_LATCH_BIT = 0;
    localparam int ST_OVR_BIT   = 1;

    // tie-off defaults of straps without a pin
    localparam logic [IND_EN_W-1:0]  IND_EN_TIE  = 6'h3F;
    localparam logic [IND_FUN_W-1:0] IND_FUN_TIE = 2'h0;
    localparam logic MANUAL_X_TIE = 1'b0;
    localparam logic HB_OFF_TIE   = 1'b0;
    localparam logic SPEED_TIE    = 1'b1;
    localparam logic DUPLEX_TIE   = 1'b1;
    localparam logic [2:0] XCTL_RST = 3'h4;

    // port 1 mode codes
    localparam logic [2:0] MODE_INT_PHY  = 3'h7;
    localparam logic [2:0] MODE_MII_PHY  = 3'h0;
    localparam logic [2:0] MODE_RMII_PHY = 3'h1;
    localparam logic [2:0] MODE_MII_MAC  = 3'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [IND_EN_W-1:0]  ind_en;
        logic [IND_FUN_W-1:0] ind_fun;
        logic                 auto_x;
        logic                 manual_x;
        logic                 an;
        logic                 hb_off;
    } ssd_straps_t;

    localparam ssd_straps_t STRAPS_RST = '{IND_EN_TIE, IND_FUN_TIE, 1'b0,
                                           MANUAL_X_TIE, 1'b0, HB_OFF_TIE};
endpackage

// [ssd_strap_if.sv]
// link between the register block and the strap latch
`timescale 1ns/1ps
interface ssd_strap_if;
    import ssd_pkg::*;
    logic        sample;
    logic        restore;
    logic        ee_load;
    ssd_straps_t ee_data;
    logic        pin_x;
    logic [2:0]  p1_mode;
    ssd_straps_t eff;
    ssd_straps_t latched;
    logic        load_dflt;
    logic        is_latched;
    logic        override;

    modport ctrl (output sample, restore, ee_load, ee_data, pin_x, p1_mode,
                  input eff, latched, load_dflt, is_latched, override);
    modport latch (input sample, restore, ee_load, ee_data, pin_x, p1_mode,
                   output eff, latched, load_dflt, is_latched, override);
endinterface

// [ssd_strap_latch.sv]
// strap latch: sampled values, loader override and restore
`timescale 1ns/1ps
module ssd_strap_latch
    import ssd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    ssd_strap_if.latch sif
);
    ssd_straps_t latched_q, latched_d;
    ssd_straps_t eff_q,     eff_d;
    logic        load_q,    load_d;
    logic        flag_q,    flag_d;
    logic        ovr_q,     ovr_d;

    always_comb
    begin
        latched_d = latched_q;
        eff_d     = eff_q;
        load_d    = 1'b0;
        flag_d    = flag_q;
        ovr_d     = ovr_q;
        // R10: sample straps on reset release
        if (sif.sample)
        begin
            latched_d = '{IND_EN_TIE, IND_FUN_TIE, sif.pin_x, MANUAL_X_TIE,
                          sif.p1_mode == MODE_INT_PHY, HB_OFF_TIE};
            eff_d     = latched_d;
            load_d    = 1'b1;
            flag_d    = 1'b1;
            ovr_d     = 1'b0;
        end
        // R10: loader values replace straps
        else if (sif.ee_load)
        begin
            eff_d  = sif.ee_data;
            load_d = 1'b1;
            ovr_d  = 1'b1;
        end
        // R11: restore latched, no resample
        else if (sif.restore)
        begin
            eff_d  = latched_q;
            load_d = 1'b1;
            ovr_d  = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            latched_q <= STRAPS_RST;
            eff_q     <= STRAPS_RST;
            load_q    <= 1'b0;
            flag_q    <= 1'b0;
            ovr_q     <= 1'b0;
        end
        else
        begin
            latched_q <= latched_d;
            eff_q     <= eff_d;
            load_q    <= load_d;
            flag_q    <= flag_d;
            ovr_q     <= ovr_d;
        end
    end

    assign sif.eff        = eff_q;
    assign sif.latched    = latched_q;
    assign sif.load_dflt  = load_q;
    assign sif.is_latched = flag_q;
    assign sif.override   = ovr_q;

    AST_EE_OVERRIDE: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        sif.ee_load && !sif.sample |=> eff_q == $past(sif.ee_data) && load_q)
        else $error("loader values not taken");

    AST_RESTORE_NO_RESAMPLE: assert property (@(posedge aclk) // R11
        disable iff (!aresetn)
        sif.restore && !sif.ee_load && !sif.sample
        |=> eff_q == $past(latched_q) && $stable(latched_q))
        else $error("restore did not return latched straps");
endmodule
